/* File: rtl/dsp_regs.svh */
// Constants of the display serial write port
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

`define DSP_BYTE_BITS 8
`define DSP_BITCNT_W 3
`define DSP_BITCNT_LAST 3'h7
`define DSP_COORD_W 9
`define DSP_ADDR_W 17
`define DSP_PIXEL_W 16
`define DSP_FRAME_BYTES 172800
`define DSP_PIXEL_BYTES 2
`define DSP_COLS 240
`define DSP_MAX_COL 9'h0EF
`define DSP_MAX_ROW 9'h13F
`define DSP_CMD_NOP 8'h00
`define DSP_CMD_COL_SET 8'h2A
`define DSP_CMD_ROW_SET 8'h2B
`define DSP_CMD_MEM_WRITE 8'h2C
`define DSP_CMD_SCAN_SET 8'h36
`define DSP_SCAN_ROW_DEC_BIT 7
`define DSP_SCAN_COL_DEC_BIT 6
`define DSP_SCAN_ROW_FIRST_BIT 5
`define DSP_ARG_LAST 2'h3
// Pin synchroniser start: panel held in reset, backlight input high, so the light does not blink off after reset
`define DSP_PIN_SYNC_RESET 3'h2

`endif

/* File: rtl/dsp_pkg.sv */
// Types shared by the display serial write port
`include "dsp_regs.svh"

package dsp_pkg;

	typedef logic [`DSP_COORD_W-1:0] dsp_coord_t;

	typedef struct packed {
		logic is_data;
		logic [`DSP_BYTE_BITS-1:0] value;
	} dsp_byte_t;

	typedef struct packed {
		dsp_coord_t col_start;
		dsp_coord_t col_end;
		dsp_coord_t row_start;
		dsp_coord_t row_end;
	} dsp_window_t;

	typedef struct packed {
		logic row_dec;
		logic col_dec;
		logic row_first;
	} dsp_scan_t;

	typedef enum logic [2:0] {
		DSP_ST_IDLE,
		DSP_ST_COL_ARG,
		DSP_ST_ROW_ARG,
		DSP_ST_SCAN_ARG,
		DSP_ST_MEM_WRITE
	} dsp_state_t;

endpackage

/* File: rtl/dsp_sync2.sv */
// Two-flop synchroniser for level signals
`timescale 1ns/10ps
`default_nettype none

module dsp_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RESET_VALUE;
			sync_reg <= RESET_VALUE;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule // dsp_sync2

`default_nettype wire

/* File: rtl/dsp_pixel_addr.sv */
// Pixel write address stepper over the programmed window
`timescale 1ns/10ps
`default_nettype none

module dsp_pixel_addr
	import dsp_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire dsp_window_t window,
	input wire dsp_scan_t scan,
	input wire logic start,
	input wire logic step,
	output logic [`DSP_ADDR_W-1:0] addr
);

	dsp_coord_t col_reg, col_next, row_reg, row_next;
	logic col_wrap, row_wrap;
	dsp_coord_t col_adv, row_adv;

	// Returns the following coordinate; bit above flags wrap back to the first
	function automatic logic [`DSP_COORD_W:0] advance(dsp_coord_t cur, dsp_coord_t lo, dsp_coord_t hi,
			logic dec);
		if (!dec)
			advance = (cur >= hi) ? {1'b1, lo} : {1'b0, cur + 1'b1};
		else
			advance = (cur <= lo) ? {1'b1, hi} : {1'b0, cur - 1'b1};
	endfunction

	always_comb begin
		{col_wrap, col_adv} = advance(col_reg, window.col_start, window.col_end, scan.col_dec);
		{row_wrap, row_adv} = advance(row_reg, window.row_start, window.row_end, scan.row_dec);
		col_next = col_reg;
		row_next = row_reg;
		if (start) begin
			col_next = scan.col_dec ? window.col_end : window.col_start;
			row_next = scan.row_dec ? window.row_end : window.row_start;
		end else if (step) begin
			if (!scan.row_first) begin
				col_next = col_adv;
				if (col_wrap)
					row_next = row_adv;
			end else begin
				row_next = row_adv;
				if (row_wrap)
					col_next = col_adv;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			col_reg <= '0;
			row_reg <= '0;
		end else begin
			col_reg <= col_next;
			row_reg <= row_next;
		end
	end

	assign addr = `DSP_ADDR_W'(row_reg * `DSP_ADDR_W'(`DSP_COLS)) + `DSP_ADDR_W'(col_reg);

endmodule // dsp_pixel_addr

`default_nettype wire

/* File: rtl/dsp_display_port.sv */
// Display module serial write port with frame memory and backlight control
//
// Summary of operation
// - Serial bits are taken only while chip select is low; raising it abandons a partial byte.
// - The command/data select level caught with a byte's last bit marks it as data (high) or command (low).
// - While panel reset is low the controller state is held in reset; releasing it lets it run.
// - One bit is sampled from the data line on each rising edge of the serial clock.
// - Every eight bits form one command or data byte.
// - Each bit is captured on the first clock edge of its cycle, so the host sets it up before that edge.
// - The port is write-only and has no read-back output on the serial side.
// - A pixel is one 16-bit RGB565 value sent as two bytes, high byte first.
// - The write address steps through columns and rows in the direction the scan setting fixes.
// - Pixels are held in a frame memory of 172800 bytes.
// - A floating backlight input is pulled up, so the backlight stays on.
// - A low backlight input turns the backlight off.
// - A high backlight input turns the backlight on.
`timescale 1ns/10ps
`default_nettype none

module dsp_display_port
	import dsp_pkg::*;
#(
	parameter int FRAME_BYTES = `DSP_FRAME_BYTES,
	parameter int PIXEL_BYTES = `DSP_PIXEL_BYTES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic chip_select_n,
	input wire logic cmd_data_select,
	input wire logic panel_reset_n,
	input wire logic backlight_control,
	input wire logic backlight_control_floating,
	input wire logic [`DSP_ADDR_W-1:0] pixel_read_addr,
	output logic [`DSP_PIXEL_W-1:0] pixel_read_data,
	output logic backlight_on,
	output logic controller_in_reset,
	output logic [`DSP_BYTE_BITS-1:0] last_command,
	output logic pixel_written
);

	localparam int FRAME_WORDS = FRAME_BYTES / PIXEL_BYTES;

	// ---------------- Link side, on the host's serial clock ----------------

	logic link_clear_n;
	logic [`DSP_BYTE_BITS-1:0] shift_reg, shift_next;
	logic [`DSP_BITCNT_W-1:0] bitcnt_reg, bitcnt_next;
	dsp_byte_t hold0_reg, hold0_next, hold1_reg, hold1_next;
	logic wr_slot_reg, wr_slot_next;
	logic link_toggle_reg, link_toggle_next;
	logic byte_done;

	// chip select gates link
	// Deasserting chip select clears the bit counter without a clock edge, since the
	// serial clock stands still outside a frame; the holding slots and toggle keep going.
	assign link_clear_n = rstn & ~chip_select_n;

	always_comb begin
		shift_next = {shift_reg[`DSP_BYTE_BITS-2:0], serial_data};
		bitcnt_next = bitcnt_reg + 1'b1;
		byte_done = (bitcnt_reg == `DSP_BITCNT_LAST);
	end

	always_ff @(posedge serial_clock or negedge link_clear_n) begin
		if (!link_clear_n) begin
			shift_reg <= '0;
			bitcnt_reg <= '0;
		end else begin
			shift_reg <= shift_next;
			bitcnt_reg <= bitcnt_next;
		end
	end

	always_comb begin
		hold0_next = hold0_reg;
		hold1_next = hold1_reg;
		wr_slot_next = wr_slot_reg;
		link_toggle_next = link_toggle_reg;
		if (byte_done && !chip_select_n) begin
			if (!wr_slot_reg)
				hold0_next = '{is_data: cmd_data_select, value: shift_next};
			else
				hold1_next = '{is_data: cmd_data_select, value: shift_next};
			wr_slot_next = ~wr_slot_reg;
			link_toggle_next = ~link_toggle_reg;
		end
	end

	// Two slots: the core needs up to three of its cycles to notice a byte, longer than
	// one byte time on a fast link, so each slot is left alone for two byte times.
	always_ff @(posedge serial_clock or negedge rstn) begin
		if (!rstn) begin
			hold0_reg <= '0;
			hold1_reg <= '0;
			wr_slot_reg <= 1'b0;
			link_toggle_reg <= 1'b0;
		end else begin
			hold0_reg <= hold0_next;
			hold1_reg <= hold1_next;
			wr_slot_reg <= wr_slot_next;
			link_toggle_reg <= link_toggle_next;
		end
	end

	// ---------------- Crossings into the core clock ----------------

	logic toggle_sync;
	logic panel_reset_n_sync;
	logic backlight_sync;
	logic floating_sync;

	dsp_sync2 #(
		.WIDTH(1),
		.RESET_VALUE(1'b0)
	) u_toggle_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in(link_toggle_reg),
		.sync_out(toggle_sync)
	);

	dsp_sync2 #(
		.WIDTH(3),
		.RESET_VALUE(`DSP_PIN_SYNC_RESET)
	) u_pin_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in({panel_reset_n, backlight_control, backlight_control_floating}),
		.sync_out({panel_reset_n_sync, backlight_sync, floating_sync})
	);

	// ---------------- Core, on the system clock ----------------

	logic seen_toggle_reg, seen_toggle_next;
	logic rd_slot_reg, rd_slot_next;
	logic byte_event;
	dsp_byte_t rx_byte;

	always_comb begin
		byte_event = (toggle_sync != seen_toggle_reg);
		seen_toggle_next = toggle_sync;
		rd_slot_next = byte_event ? ~rd_slot_reg : rd_slot_reg;
		rx_byte = rd_slot_reg ? hold1_reg : hold0_reg;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			seen_toggle_reg <= 1'b0;
			rd_slot_reg <= 1'b0;
		end else begin
			seen_toggle_reg <= seen_toggle_next;
			rd_slot_reg <= rd_slot_next;
		end
	end

	// Command decoder and pixel assembly
	dsp_state_t state_reg, state_next;
	logic [1:0] arg_cnt_reg, arg_cnt_next;
	logic [`DSP_BYTE_BITS-1:0] arg_hi_reg, arg_hi_next;
	dsp_window_t window_reg, window_next;
	dsp_scan_t scan_reg, scan_next;
	logic pix_phase_reg, pix_phase_next;
	logic [`DSP_BYTE_BITS-1:0] pix_hi_reg, pix_hi_next;
	logic [`DSP_BYTE_BITS-1:0] last_cmd_reg, last_cmd_next;
	logic addr_start, addr_step;
	logic mem_we;
	logic [`DSP_PIXEL_W-1:0] mem_wdata;
	logic in_reset;
	dsp_coord_t arg_word;
	dsp_window_t window_default;

	always_comb begin
		window_default = '{col_start: '0, col_end: `DSP_MAX_COL, row_start: '0, row_end: `DSP_MAX_ROW};
		in_reset = ~panel_reset_n_sync;
		arg_word = `DSP_COORD_W'({arg_hi_reg, rx_byte.value});
		state_next = state_reg;
		arg_cnt_next = arg_cnt_reg;
		arg_hi_next = arg_hi_reg;
		window_next = window_reg;
		scan_next = scan_reg;
		pix_phase_next = pix_phase_reg;
		pix_hi_next = pix_hi_reg;
		last_cmd_next = last_cmd_reg;
		addr_start = 1'b0;
		addr_step = 1'b0;
		mem_we = 1'b0;
		mem_wdata = {pix_hi_reg, rx_byte.value};
		if (in_reset) begin
			state_next = DSP_ST_IDLE;
			arg_cnt_next = '0;
			arg_hi_next = '0;
			window_next = window_default;
			scan_next = '0;
			pix_phase_next = 1'b0;
			pix_hi_next = '0;
			last_cmd_next = `DSP_CMD_NOP;
		end else if (byte_event && !rx_byte.is_data) begin
			last_cmd_next = rx_byte.value;
			arg_cnt_next = '0;
			pix_phase_next = 1'b0;
			unique case (rx_byte.value)
				`DSP_CMD_COL_SET: state_next = DSP_ST_COL_ARG;
				`DSP_CMD_ROW_SET: state_next = DSP_ST_ROW_ARG;
				`DSP_CMD_SCAN_SET: state_next = DSP_ST_SCAN_ARG;
				`DSP_CMD_MEM_WRITE: begin
					state_next = DSP_ST_MEM_WRITE;
					addr_start = 1'b1;
				end
				default: state_next = DSP_ST_IDLE;
			endcase
		end else if (byte_event) begin
			unique case (state_reg)
				DSP_ST_IDLE: begin
					state_next = DSP_ST_IDLE;
				end
				DSP_ST_COL_ARG, DSP_ST_ROW_ARG: begin
					arg_cnt_next = arg_cnt_reg + 1'b1;
					arg_hi_next = rx_byte.value;
					if (arg_cnt_reg[0]) begin
						if (state_reg == DSP_ST_COL_ARG) begin
							if (arg_cnt_reg[1])
								window_next.col_end = arg_word;
							else
								window_next.col_start = arg_word;
						end else begin
							if (arg_cnt_reg[1])
								window_next.row_end = arg_word;
							else
								window_next.row_start = arg_word;
						end
					end
					if (arg_cnt_reg == `DSP_ARG_LAST)
						state_next = DSP_ST_IDLE;
				end
				DSP_ST_SCAN_ARG: begin
					scan_next.row_dec = rx_byte.value[`DSP_SCAN_ROW_DEC_BIT];
					scan_next.col_dec = rx_byte.value[`DSP_SCAN_COL_DEC_BIT];
					scan_next.row_first = rx_byte.value[`DSP_SCAN_ROW_FIRST_BIT];
					state_next = DSP_ST_IDLE;
				end
				DSP_ST_MEM_WRITE: begin
					if (!pix_phase_reg) begin
						pix_hi_next = rx_byte.value;
						pix_phase_next = 1'b1;
					end else begin
						mem_we = 1'b1;
						addr_step = 1'b1;
						pix_phase_next = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= DSP_ST_IDLE;
			arg_cnt_reg <= '0;
			arg_hi_reg <= '0;
			window_reg <= '{col_start: '0, col_end: `DSP_MAX_COL, row_start: '0, row_end: `DSP_MAX_ROW};
			scan_reg <= '0;
			pix_phase_reg <= 1'b0;
			pix_hi_reg <= '0;
			last_cmd_reg <= `DSP_CMD_NOP;
		end else begin
			state_reg <= state_next;
			arg_cnt_reg <= arg_cnt_next;
			arg_hi_reg <= arg_hi_next;
			window_reg <= window_next;
			scan_reg <= scan_next;
			pix_phase_reg <= pix_phase_next;
			pix_hi_reg <= pix_hi_next;
			last_cmd_reg <= last_cmd_next;
		end
	end

	logic [`DSP_ADDR_W-1:0] wr_addr;

	dsp_pixel_addr u_pixel_addr (
		.clock(clock),
		.rstn(rstn),
		.window(window_reg),
		.scan(scan_reg),
		.start(addr_start),
		.step(addr_step),
		.addr(wr_addr)
	);

	// frame memory storage
	// Kept as 16-bit words; no reset, since contents after power-up are undefined anyway.
	logic [`DSP_PIXEL_W-1:0] frame_memory [FRAME_WORDS];
	logic [`DSP_PIXEL_W-1:0] rd_data_reg, rd_data_next;
	logic wr_in_range;

	always_comb begin
		wr_in_range = (int'(wr_addr) < FRAME_WORDS);
		rd_data_next = (int'(pixel_read_addr) < FRAME_WORDS) ? frame_memory[pixel_read_addr] : '0;
	end

	always_ff @(posedge clock) begin
		if (mem_we && wr_in_range)
			frame_memory[wr_addr] <= mem_wdata;
	end

	// Output flops
	logic backlight_reg, backlight_next;
	logic ctrl_reset_reg, ctrl_reset_next;
	logic written_reg, written_next;

	always_comb begin
		backlight_next = floating_sync | backlight_sync;
		ctrl_reset_next = in_reset;
		written_next = mem_we && wr_in_range;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_data_reg <= '0;
			backlight_reg <= 1'b1;
			ctrl_reset_reg <= 1'b1;
			written_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			backlight_reg <= backlight_next;
			ctrl_reset_reg <= ctrl_reset_next;
			written_reg <= written_next;
		end
	end

	assign pixel_read_data = rd_data_reg;
	assign backlight_on = backlight_reg;
	assign controller_in_reset = ctrl_reset_reg;
	assign last_command = last_cmd_reg;
	assign pixel_written = written_reg;

endmodule // dsp_display_port

`default_nettype wire

/* File: dv/dsp_display_port_checker.sv */
// Concurrent checks on the display serial write port
`timescale 1ns/10ps
`default_nettype none
`include "dsp_regs.svh"

module dsp_display_port_checker
	import dsp_pkg::*;
#(
	parameter int FRAME_BYTES = `DSP_FRAME_BYTES,
	parameter int PIXEL_BYTES = `DSP_PIXEL_BYTES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic chip_select_n,
	input wire logic panel_reset_n,
	input wire logic backlight_control,
	input wire logic backlight_control_floating,
	input wire logic [`DSP_ADDR_W-1:0] pixel_read_addr,
	input wire logic [`DSP_PIXEL_W-1:0] pixel_read_data,
	input wire logic backlight_on,
	input wire logic controller_in_reset,
	input wire logic [`DSP_BYTE_BITS-1:0] last_command,
	input wire logic pixel_written
);
	localparam int WORDS = FRAME_BYTES / PIXEL_BYTES;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_float_lit_on: assert property (backlight_control_floating[*4] |-> backlight_on)
		else $error("backlight off while pin floats");
	a_low_lit_off: assert property ((!backlight_control && !backlight_control_floating)[*4] |-> !backlight_on)
		else $error("backlight on with low input");
	a_high_lit_on: assert property (backlight_control[*4] |-> backlight_on)
		else $error("backlight off with high input");
	a_panel_rst_on: assert property ((!panel_reset_n)[*4] |-> controller_in_reset)
		else $error("controller not held in reset");
	a_panel_rst_off: assert property (panel_reset_n[*4] |-> !controller_in_reset)
		else $error("controller held after release");
	a_rst_no_cmd: assert property (controller_in_reset[*2] |-> $stable(last_command) && !pixel_written)
		else $error("traffic taken during panel reset");
	a_idle_no_cmd: assert property (chip_select_n[*6] |-> $stable(last_command))
		else $error("command changed while deselected");
	a_pixel_after_cmd: assert property (pixel_written |-> last_command == `DSP_CMD_MEM_WRITE)
		else $error("pixel stored outside memory write");
	a_pixel_spacing: assert property ($rose(pixel_written) |=> (!pixel_written)[*3])
		else $error("pixels closer than two bytes");
	a_read_bound: assert property (pixel_read_addr >= WORDS |=> pixel_read_data == '0)
		else $error("data read beyond frame memory");
	c_pixel: cover property (pixel_written);
	c_command: cover property ($changed(last_command));
	c_dark: cover property (!backlight_on);
	c_panel_rst: cover property (controller_in_reset);
endmodule // dsp_display_port_checker

bind dsp_display_port dsp_display_port_checker #(.FRAME_BYTES(FRAME_BYTES), .PIXEL_BYTES(PIXEL_BYTES))
	u_dsp_display_port_checker (.clock(clock), .rstn(rstn), .chip_select_n(chip_select_n),
	.panel_reset_n(panel_reset_n), .backlight_control(backlight_control),
	.backlight_control_floating(backlight_control_floating), .pixel_read_addr(pixel_read_addr),
	.pixel_read_data(pixel_read_data), .backlight_on(backlight_on), .controller_in_reset(controller_in_reset),
	.last_command(last_command), .pixel_written(pixel_written));
`default_nettype wire

/* File: dv/dsp_host.sv */
// Host-side serial write driver for the display port
`timescale 1ns/10ps
`default_nettype none

module dsp_host (
	output logic serial_clock,
	output logic serial_data,
	output logic chip_select_n,
	output logic cmd_data_select
);
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		chip_select_n = 1'b1;
		cmd_data_select = 1'b0;
	end
	task automatic send_bits(input logic dc, input logic [7:0] value, input int nbits);
		chip_select_n = 1'b0;
		cmd_data_select = dc;
		for (int i = 7; i > 7 - nbits; i--) begin
			serial_data = value[i];
			#15 serial_clock = 1'b1;
			#15 serial_clock = 1'b0;
		end
		// Hold time over, so the line no longer shows the last bit
		serial_data = ~serial_data;
	endtask
	task automatic release_bus();
		#15 chip_select_n = 1'b1;
		cmd_data_select = ~cmd_data_select;
		#15;
	endtask
endmodule // dsp_host
`default_nettype wire

/* File: dv/test_dsp_display_port.sv */
// Self-checking bench for the display serial write port
`timescale 1ns/10ps
`default_nettype none
`include "dsp_regs.svh"

module test_dsp_display_port
	import dsp_pkg::*;
;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic panel_reset_n = 1'b1;
	logic backlight_control = 1'b1;
	logic backlight_control_floating = 1'b0;
	logic [`DSP_ADDR_W-1:0] pixel_read_addr = '0;
	wire logic sck, sda, csn, dcs, backlight_on, controller_in_reset, pixel_written;
	wire logic [`DSP_PIXEL_W-1:0] pixel_read_data;
	wire logic [`DSP_BYTE_BITS-1:0] last_command;
	int failures = 0;
	int total_checks = 0;
	int pix_count = 0;

	always #50 clock = ~clock;
	always @(posedge clock) if (pixel_written === 1'b1) pix_count <= pix_count + 1;

	dsp_display_port u_dsp_display_port (.clock(clock), .rstn(rstn), .serial_clock(sck), .serial_data(sda),
		.chip_select_n(csn), .cmd_data_select(dcs), .panel_reset_n(panel_reset_n),
		.backlight_control(backlight_control), .backlight_control_floating(backlight_control_floating),
		.pixel_read_addr(pixel_read_addr), .pixel_read_data(pixel_read_data), .backlight_on(backlight_on),
		.controller_in_reset(controller_in_reset), .last_command(last_command), .pixel_written(pixel_written));
	dsp_host u_dsp_host (.serial_clock(sck), .serial_data(sda), .chip_select_n(csn), .cmd_data_select(dcs));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Gap keeps each byte longer than the decoder needs
	task automatic wbyte(input logic dc, input logic [7:0] v);
		u_dsp_host.send_bits(dc, v, 8);
		#200;
	endtask
	task automatic settle();
		repeat (3) @(negedge clock);
	endtask
	task automatic wwin(input logic [7:0] c, input logic [7:0] s, input logic [7:0] e);
		wbyte(1'b0, c);
		wbyte(1'b1, 8'h00);
		wbyte(1'b1, s);
		wbyte(1'b1, 8'h00);
		wbyte(1'b1, e);
	endtask
	task automatic pix(input logic [15:0] p);
		wbyte(1'b1, p[15:8]);
		wbyte(1'b1, p[7:0]);
	endtask
	task automatic rd(input logic [16:0] a, input logic [15:0] exp);
		@(negedge clock);
		pixel_read_addr = a;
		@(negedge clock);
		check(pixel_read_data, exp);
	endtask

	task automatic t_backlight();
		logic [2:0] tv [3];
		tv = '{3'b101, 3'b000, 3'b011};
		for (int i = 0; i < 3; i++) begin
			{backlight_control_floating, backlight_control} = tv[i][2:1];
			repeat (5) @(negedge clock);
			check(backlight_on, tv[i][0]);
		end
	endtask
	task automatic t_window_write();
		wwin(`DSP_CMD_COL_SET, 8'h05, 8'h06);
		wwin(`DSP_CMD_ROW_SET, 8'h03, 8'h04);
		wbyte(1'b0, `DSP_CMD_SCAN_SET);
		wbyte(1'b1, 8'h00);
		settle();
		check(last_command, `DSP_CMD_SCAN_SET);
		wbyte(1'b0, `DSP_CMD_MEM_WRITE);
		pix(16'hA1B2);
		pix(16'hC3D4);
		pix(16'hE5F6);
		pix(16'h1234);
		wbyte(1'b0, `DSP_CMD_SCAN_SET);
		wbyte(1'b1, 8'h20);
		wbyte(1'b0, `DSP_CMD_MEM_WRITE);
		pix(16'h5555);
		pix(16'h6666);
		u_dsp_host.release_bus();
		settle();
		rd(17'd725, 16'h5555);
		rd(17'd726, 16'hC3D4);
		rd(17'd965, 16'h6666);
		rd(17'd966, 16'h1234);
		check(pix_count, 6);
		wbyte(1'b0, `DSP_CMD_SCAN_SET);
		wbyte(1'b1, 8'hC0);
		wbyte(1'b0, `DSP_CMD_MEM_WRITE);
		pix(16'h7777);
		pix(16'h8888);
		pix(16'h9999);
		u_dsp_host.release_bus();
		settle();
		rd(17'd966, 16'h7777);
		rd(17'd965, 16'h8888);
		rd(17'd726, 16'h9999);
		check(pix_count, 9);
	endtask
	task automatic t_partial();
		u_dsp_host.send_bits(1'b0, 8'hFF, 5);
		u_dsp_host.release_bus();
		wbyte(1'b0, `DSP_CMD_NOP);
		u_dsp_host.release_bus();
		settle();
		check(last_command, `DSP_CMD_NOP);
	endtask
	task automatic t_panel_reset();
		@(negedge clock);
		panel_reset_n = 1'b0;
		repeat (5) @(negedge clock);
		check(controller_in_reset, 1'b1);
		wbyte(1'b0, `DSP_CMD_COL_SET);
		u_dsp_host.release_bus();
		settle();
		check(last_command, `DSP_CMD_NOP);
		panel_reset_n = 1'b1;
		repeat (5) @(negedge clock);
		check(controller_in_reset, 1'b0);
		wbyte(1'b0, `DSP_CMD_MEM_WRITE);
		pix(16'h0BEE);
		wbyte(1'b1, 8'h77);
		wbyte(1'b0, `DSP_CMD_NOP);
		u_dsp_host.release_bus();
		settle();
		rd(17'd0, 16'h0BEE);
		check(pix_count, 10);
		rd(17'd86400, 16'h0000);
	endtask

	initial begin
		repeat (5) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		check(controller_in_reset, 1'b0);
		t_backlight();
		t_window_write();
		t_partial();
		t_panel_reset();
		test_done();
	end
	// Whole sequence needs about 26 us
	initial begin
		#400000;
		failures++;
		test_done();
	end
endmodule // test_dsp_display_port
`default_nettype wire
